// ---- design/pump_cfg_map.vh ----
// Purpose: Register offsets, field positions and reset values of the pump bank
// Assumes: 16-bit holding registers addressed by register number
// Notes: Definitions only
`ifndef PUMP_CFG_MAP_VH
`define PUMP_CFG_MAP_VH

`define ADDR_W 16
`define DATA_W 16

`define OFS_BOILER_OVERRUN 16'h011B
`define OFS_AUX1_OUTPUT 16'h011C
`define OFS_AUX1_CONTROL 16'h011D
`define OFS_RESERVED_SLOT 16'h011E
`define OFS_SYSTEM_OUTPUT 16'h011F
`define OFS_SYSTEM_CONTROL 16'h0120
`define OFS_SYSTEM_OVERRUN 16'h0121
`define OFS_EXERCISE_INTERVAL 16'h0122
`define OFS_EXERCISE_DURATION 16'h0123
`define OFS_HEATING_START_DELAY 16'h0124
`define OFS_BOILER_START_DELAY 16'h0125
`define OFS_SYSTEM_START_DELAY 16'h0126
`define OFS_AUX1_START_DELAY 16'h0127
`define OFS_HEATING_DEMAND_OPTS 16'h0128
`define OFS_HEATING_FORCE_OPTS 16'h0129
`define OFS_HOT_WATER_DEMAND_OPTS 16'h012A

`define OUTPUT_SEL_W 2
`define OUTPUT_NONE 2'h0
`define OUTPUT_PUMP_A 2'h1
`define OUTPUT_PUMP_B 2'h2
`define OUTPUT_PUMP_C 2'h3
`define CONTROL_AUTO 1'h0
`define CONTROL_ON 1'h1

`define TIME_MAX 16'hFD20
`define TIME_NOT_CONFIGURED 16'hFFFF

`define DEMAND_OPTS_MASK 16'hE06F
`define FORCE_OPTS_MASK 16'hC1FF

`define BIT_AUX_Z 15
`define BIT_AUX_Y 14
`define BIT_AUX_X 13
`define BIT_HW_SERVICE 6
`define BIT_CH_SERVICE 5
`define BIT_HW_DEMAND 3
`define BIT_CH_DEMAND 2
`define BIT_LOCAL_BURNER 1
`define BIT_FAULT_INHIBIT 0

`define BIT_LEAD_LAG 15
`define BIT_LOCAL_DEMAND 14
`define BIT_OFF_HW_HIGH_LIMIT 8
`define BIT_OFF_HW_ANTI_COND 7
`define BIT_OFF_CH_ANTI_COND 6
`define BIT_OFF_HW_PRIORITY 5
`define BIT_ON_HW_FROST 4
`define BIT_ON_CH_FROST 3
`define BIT_ON_LEAD_LAG_SLAVE 2
`define BIT_ON_LOCAL_BURNER 1
`define BIT_ON_OUTLET_HIGH_LIMIT 0

`define RST_OUTPUT_SEL 2'h0
`define RST_CONTROL 1'h0
`define RST_TIME 16'hFFFF
`define RST_INTERVAL 16'h0000
`define RST_OPTS 16'h0000

`endif

// ---- design/pump_demand_opts.v ----
// Purpose: Decode a demand option map into its enable flags
// Assumes: Map already has reserved bits cleared
// Notes: Combinational
`timescale 1ns/1ps
`default_nettype none
`include "pump_cfg_map.vh"
module pump_demand_opts (
	input wire [15:0] opts,
	output wire auxZ,
	output wire auxY,
	output wire auxX,
	output wire hwService,
	output wire chService,
	output wire hwDemand,
	output wire chDemand,
	output wire localBurner,
	output wire faultInhibit
);
	assign auxZ = opts[`BIT_AUX_Z];
	assign auxY = opts[`BIT_AUX_Y];
	assign auxX = opts[`BIT_AUX_X];
	assign hwService = opts[`BIT_HW_SERVICE];
	assign chService = opts[`BIT_CH_SERVICE];
	assign hwDemand = opts[`BIT_HW_DEMAND];
	assign chDemand = opts[`BIT_CH_DEMAND];
	assign localBurner = opts[`BIT_LOCAL_BURNER];
	assign faultInhibit = opts[`BIT_FAULT_INHIBIT];
endmodule // pump_demand_opts
`default_nettype wire

// ---- design/pump_force_opts.v ----
// Purpose: Decode a force option map into force-off and force-on vectors
// Assumes: Map already has reserved bits cleared
// Notes: Combinational
`timescale 1ns/1ps
`default_nettype none
`include "pump_cfg_map.vh"
module pump_force_opts (
	input wire [15:0] opts,
	output wire leadLag,
	output wire localDemand,
	output wire [3:0] forceOff,
	output wire [4:0] forceOn
);
	assign leadLag = opts[`BIT_LEAD_LAG];
	assign localDemand = opts[`BIT_LOCAL_DEMAND];
	// Order: hw high limit, hw anti-cond, ch anti-cond, hw priority
	assign forceOff = opts[`BIT_OFF_HW_HIGH_LIMIT:`BIT_OFF_HW_PRIORITY];
	// Order: hw frost, ch frost, lead-lag slave, burner, outlet high limit
	assign forceOn = opts[`BIT_ON_HW_FROST:`BIT_ON_OUTLET_HIGH_LIMIT];
endmodule // pump_force_opts
`default_nettype wire

// ---- design/pump_config_register_bank.v ----
// Purpose: Pump configuration holding registers reached by register number
// Assumes: Serial slave logic on clk presents decoded reads and writes
// Notes: Read data registered one cycle after rdEn
// Notes on behaviour
// - Output select: 0 none, 1 to 3 pump outputs A, B, C.
// - Control: 0 automatic demand operation, 1 pump held on.
// - Overrun times are seconds 0 to 64800; all-ones means unconfigured.
// - Start delays are seconds 0 to 64800; all-ones means unconfigured.
// - Demand map bits 15, 14, 13 enable demand from aux Z, Y, X.
// - Demand map bits 12 to 7 read zero; bit 4 reserved.
// - Demand map bit 6 hot-water service, bit 5 heating service.
// - Demand map bits 3, 2, 1: hot-water, heating, local burner demand.
// - Demand map bit 0 inhibits local demand while faults present.
// - Force map bit 15 lead-lag use, bit 14 local demand use.
// - Force map bits 13 to 9 reserved, always read zero.
// - Force map bits 8 to 5 force pump off in listed conditions.
// - Force map bits 4 to 0 force pump on in listed conditions.
`timescale 1ns/1ps
`default_nettype none
`include "pump_cfg_map.vh"
module pump_config_register_bank #(
	parameter ADDR_W = `ADDR_W,
	parameter DATA_W = `DATA_W
) (
	input wire clk,
	input wire rst,
	input wire wrEn,
	input wire rdEn,
	input wire [ADDR_W-1:0] addr,
	input wire [DATA_W-1:0] wrData,
	output reg [DATA_W-1:0] rdData_q,
	output reg rdValid_q,
	output reg addrHit_q,
	output reg [15:0] boilerOverrun_q,
	output reg [1:0] aux1Output_q,
	output reg aux1On_q,
	output reg [1:0] systemOutput_q,
	output reg systemOn_q,
	output reg [15:0] systemOverrun_q,
	output reg [15:0] exerciseInterval_q,
	output reg [15:0] exerciseDuration_q,
	output reg [15:0] heatingStartDelay_q,
	output reg [15:0] boilerStartDelay_q,
	output reg [15:0] systemStartDelay_q,
	output reg [15:0] aux1StartDelay_q,
	output reg [15:0] heatingDemandOpts_q,
	output reg [15:0] heatingForceOpts_q,
	output reg [15:0] hotWaterDemandOpts_q,
	output reg [8:0] heatingDemandFlags_q,
	output reg [8:0] hotWaterDemandFlags_q,
	output reg [10:0] heatingForceFlags_q
);
	// Out-of-range times are refused so consumers never see a bogus duration
	function timeOk;
		input [15:0] v;
		begin
			timeOk = (v <= `TIME_MAX) || (v == `TIME_NOT_CONFIGURED);
		end
	endfunction

	wire [15:0] wr16;
	wire wrTimeOk;
	wire wrSelOk;
	wire wrCtlOk;
	assign wr16 = wrData[15:0];
	assign wrTimeOk = timeOk(wr16);
	assign wrSelOk = (wr16[15:2] == 14'h0000);
	assign wrCtlOk = (wr16[15:1] == 15'h0000);

	always @(posedge clk) begin
		if (rst) begin
			boilerOverrun_q <= `RST_TIME;
			aux1Output_q <= `RST_OUTPUT_SEL;
			aux1On_q <= `RST_CONTROL;
			systemOutput_q <= `RST_OUTPUT_SEL;
			systemOn_q <= `RST_CONTROL;
			systemOverrun_q <= `RST_TIME;
			exerciseInterval_q <= `RST_INTERVAL;
			exerciseDuration_q <= `RST_TIME;
			heatingStartDelay_q <= `RST_TIME;
			boilerStartDelay_q <= `RST_TIME;
			systemStartDelay_q <= `RST_TIME;
			aux1StartDelay_q <= `RST_TIME;
			heatingDemandOpts_q <= `RST_OPTS;
			heatingForceOpts_q <= `RST_OPTS;
			hotWaterDemandOpts_q <= `RST_OPTS;
		end else if (wrEn) begin
			case (addr)
			`OFS_BOILER_OVERRUN: begin
				if (wrTimeOk)
					boilerOverrun_q <= wr16;
			end
			`OFS_AUX1_OUTPUT: begin
				if (wrSelOk)
					aux1Output_q <= wr16[1:0];
			end
			`OFS_AUX1_CONTROL: begin
				if (wrCtlOk)
					aux1On_q <= wr16[0];
			end
			`OFS_SYSTEM_OUTPUT: begin
				if (wrSelOk)
					systemOutput_q <= wr16[1:0];
			end
			`OFS_SYSTEM_CONTROL: begin
				if (wrCtlOk)
					systemOn_q <= wr16[0];
			end
			`OFS_SYSTEM_OVERRUN: begin
				if (wrTimeOk)
					systemOverrun_q <= wr16;
			end
			`OFS_EXERCISE_INTERVAL: begin
				exerciseInterval_q <= wr16;
			end
			`OFS_EXERCISE_DURATION: begin
				if (wrTimeOk)
					exerciseDuration_q <= wr16;
			end
			`OFS_HEATING_START_DELAY: begin
				if (wrTimeOk)
					heatingStartDelay_q <= wr16;
			end
			`OFS_BOILER_START_DELAY: begin
				if (wrTimeOk)
					boilerStartDelay_q <= wr16;
			end
			`OFS_SYSTEM_START_DELAY: begin
				if (wrTimeOk)
					systemStartDelay_q <= wr16;
			end
			`OFS_AUX1_START_DELAY: begin
				if (wrTimeOk)
					aux1StartDelay_q <= wr16;
			end
			`OFS_HEATING_DEMAND_OPTS: begin
				heatingDemandOpts_q <= wr16 & `DEMAND_OPTS_MASK;
			end
			`OFS_HEATING_FORCE_OPTS: begin
				heatingForceOpts_q <= wr16 & `FORCE_OPTS_MASK;
			end
			`OFS_HOT_WATER_DEMAND_OPTS: begin
				hotWaterDemandOpts_q <= wr16 & `DEMAND_OPTS_MASK;
			end
			default: begin
				// Reserved slot and foreign addresses are dropped
			end
			endcase
		end
	end

	reg [15:0] rdMux;
	reg hit;
	always @* begin
		rdMux = 16'h0000;
		hit = 1'b1;
		case (addr)
		`OFS_BOILER_OVERRUN: rdMux = boilerOverrun_q;
		`OFS_AUX1_OUTPUT: rdMux = {14'h0000, aux1Output_q};
		`OFS_AUX1_CONTROL: rdMux = {15'h0000, aux1On_q};
		`OFS_RESERVED_SLOT: rdMux = 16'h0000;
		`OFS_SYSTEM_OUTPUT: rdMux = {14'h0000, systemOutput_q};
		`OFS_SYSTEM_CONTROL: rdMux = {15'h0000, systemOn_q};
		`OFS_SYSTEM_OVERRUN: rdMux = systemOverrun_q;
		`OFS_EXERCISE_INTERVAL: rdMux = exerciseInterval_q;
		`OFS_EXERCISE_DURATION: rdMux = exerciseDuration_q;
		`OFS_HEATING_START_DELAY: rdMux = heatingStartDelay_q;
		`OFS_BOILER_START_DELAY: rdMux = boilerStartDelay_q;
		`OFS_SYSTEM_START_DELAY: rdMux = systemStartDelay_q;
		`OFS_AUX1_START_DELAY: rdMux = aux1StartDelay_q;
		`OFS_HEATING_DEMAND_OPTS: rdMux = heatingDemandOpts_q;
		`OFS_HEATING_FORCE_OPTS: rdMux = heatingForceOpts_q;
		`OFS_HOT_WATER_DEMAND_OPTS: rdMux = hotWaterDemandOpts_q;
		default: hit = 1'b0;
		endcase
	end

	always @(posedge clk) begin
		if (rst) begin
			rdData_q <= {DATA_W{1'b0}};
			rdValid_q <= 1'b0;
			addrHit_q <= 1'b0;
		end else begin
			rdValid_q <= rdEn;
			addrHit_q <= (rdEn | wrEn) & hit;
			if (rdEn)
				rdData_q <= {{(DATA_W-16){1'b0}}, rdMux};
		end
	end

	wire [8:0] hcDemand;
	wire [8:0] hwDemandW;
	wire hcLeadLag;
	wire hcLocal;
	wire [3:0] hcOff;
	wire [4:0] hcOn;

	pump_demand_opts heatingDemandDec (
		.opts(heatingDemandOpts_q),
		.auxZ(hcDemand[8]),
		.auxY(hcDemand[7]),
		.auxX(hcDemand[6]),
		.hwService(hcDemand[5]),
		.chService(hcDemand[4]),
		.hwDemand(hcDemand[3]),
		.chDemand(hcDemand[2]),
		.localBurner(hcDemand[1]),
		.faultInhibit(hcDemand[0])
	);

	pump_demand_opts hotWaterDemandDec (
		.opts(hotWaterDemandOpts_q),
		.auxZ(hwDemandW[8]),
		.auxY(hwDemandW[7]),
		.auxX(hwDemandW[6]),
		.hwService(hwDemandW[5]),
		.chService(hwDemandW[4]),
		.hwDemand(hwDemandW[3]),
		.chDemand(hwDemandW[2]),
		.localBurner(hwDemandW[1]),
		.faultInhibit(hwDemandW[0])
	);

	pump_force_opts heatingForceDec (
		.opts(heatingForceOpts_q),
		.leadLag(hcLeadLag),
		.localDemand(hcLocal),
		.forceOff(hcOff),
		.forceOn(hcOn)
	);

	// Decoded flags lag the option registers by one cycle to keep outputs flopped
	always @(posedge clk) begin
		if (rst) begin
			heatingDemandFlags_q <= 9'h000;
			hotWaterDemandFlags_q <= 9'h000;
			heatingForceFlags_q <= 11'h000;
		end else begin
			heatingDemandFlags_q <= hcDemand;
			hotWaterDemandFlags_q <= hwDemandW;
			heatingForceFlags_q <= {hcLeadLag, hcLocal, hcOff, hcOn};
		end
	end
endmodule // pump_config_register_bank
`default_nettype wire

// ---- dv/pump_bank_monitor.sv ----
// Purpose: Port checks on the pump configuration bank
// Assumes: Sees only the bank's ports; one clock domain
// Notes: Reserved masks are the complement of the kept bits
`timescale 1ns/1ps
`default_nettype none
module pump_bank_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic wrEn,
	input wire logic rdEn,
	input wire logic [15:0] addr,
	input wire logic [15:0] wrData,
	input wire logic [15:0] rdData_q,
	input wire logic rdValid_q,
	input wire logic addrHit_q,
	input wire logic [1:0] systemOutput_q,
	input wire logic systemOn_q,
	input wire logic [15:0] systemOverrun_q,
	input wire logic [15:0] heatingDemandOpts_q,
	input wire logic [15:0] heatingForceOpts_q,
	input wire logic [10:0] heatingForceFlags_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire logic inMap = addr >= 16'h011B && addr <= 16'h012A;
	wire logic req = rdEn || wrEn;

	read_answer_a: assert property (rdEn |=> rdValid_q)
		else $error("read not answered next cycle");
	read_quiet_a: assert property (!rdEn |=> !rdValid_q && $stable(rdData_q))
		else $error("read data moved without a read");
	map_hit_a: assert property (req && inMap |=> addrHit_q)
		else $error("mapped access not flagged");
	map_miss_a: assert property (req && !inMap |=> !addrHit_q)
		else $error("unmapped access flagged");
	miss_zero_a: assert property (
		rdEn && !inMap |=> rdData_q == 16'h0000)
		else $error("unmapped read not zero");
	demand_rsvd_a: assert property (
		(heatingDemandOpts_q & 16'h1F90) == 16'h0000)
		else $error("demand map reserved bit set");
	force_rsvd_a: assert property (
		(heatingForceOpts_q & 16'h3E00) == 16'h0000)
		else $error("force map reserved bit set");
	time_range_a: assert property (
		systemOverrun_q <= 16'hFD20 || systemOverrun_q == 16'hFFFF)
		else $error("overrun out of range");
	select_write_a: assert property (
		wrEn && addr == 16'h011F && wrData <= 16'h0003
		|=> {14'h0000, systemOutput_q} == $past(wrData))
		else $error("output select not taken");
	control_keep_a: assert property (
		wrEn && addr == 16'h0120 && wrData > 16'h0001
		|=> $stable(systemOn_q))
		else $error("bad control value taken");
	force_flags_a: assert property (
		heatingForceFlags_q == {$past(heatingForceOpts_q[15:14]),
		$past(heatingForceOpts_q[8:0])})
		else $error("force flags do not follow map");
endmodule // pump_bank_monitor
bind pump_config_register_bank pump_bank_monitor pump_bank_monitor_inst (
	.clk, .rst, .wrEn, .rdEn, .addr, .wrData, .rdData_q, .rdValid_q,
	.addrHit_q, .systemOutput_q, .systemOn_q, .systemOverrun_q,
	.heatingDemandOpts_q, .heatingForceOpts_q, .heatingForceFlags_q);
`default_nettype wire

// ---- dv/pump_bus_master.sv ----
// Purpose: Serial master stand-in issuing decoded register accesses
// Assumes: One access at a time, launched 1 ns after a rising edge
// Notes: Released address and data lines show the inverse so stale values never match
`timescale 1ns/1ps
`default_nettype none
module pump_bus_master (
	input wire logic clk,
	output logic wrEn,
	output logic rdEn,
	output logic [15:0] addr,
	output logic [15:0] wrData
);
	initial begin
		wrEn = 1'b0;
		rdEn = 1'b0;
		addr = 16'h0000;
		wrData = 16'h0000;
	end
	task automatic access(input logic w, input logic [15:0] a, d);
		@(posedge clk);
		#1;
		wrEn = w;
		rdEn = !w;
		addr = a;
		wrData = d;
		@(posedge clk);
		#1;
		wrEn = 1'b0;
		rdEn = 1'b0;
		addr = ~a;
		wrData = ~d;
	endtask
endmodule // pump_bus_master
`default_nettype wire

// ---- dv/pump_config_register_bank_tb.sv ----
// Purpose: Self-checking bench for the pump configuration bank
// Assumes: Shadow copy predicts every read
// Notes: Reset-value reads first, then boundary table, then seeded random traffic
`timescale 1ns/1ps
`default_nettype none
module pump_config_register_bank_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wrEn, rdEn, rdValid_q;
	logic [15:0] addr, wrData, rdData_q, v, r;
	logic [15:0] oBo, oSo, oEi, oEd, oHs, oBs, oSs, oAs, oHd, oHf, oWd;
	logic [1:0] oAx, oSx;
	logic oAc, oSc;
	logic [8:0] oHdf, oWdf;
	logic [10:0] oHff;
	logic [15:0] sh [0:15];
	logic [15:0] expq [$];
	logic [15:0] bnd [0:8] = '{16'h0003, 16'h0004, 16'h0001, 16'h0002,
		16'hFD20, 16'hFD21, 16'hFFFE, 16'hFFFF, 16'h0000};
	integer seed = 32'he36fe780;
	integer fail_count = 0;
	integer n_tests = 0;
	integer cycles = 0;
	integer i, j, k;
	always #2.5 clk = ~clk;
	pump_bus_master pump_bus_master_inst (.clk, .wrEn, .rdEn, .addr, .wrData);
	pump_config_register_bank pump_config_register_bank_inst (.clk, .rst,
		.wrEn, .rdEn, .addr, .wrData, .rdData_q, .rdValid_q, .addrHit_q(),
		.boilerOverrun_q(oBo), .aux1Output_q(oAx), .aux1On_q(oAc),
		.systemOutput_q(oSx), .systemOn_q(oSc), .systemOverrun_q(oSo),
		.exerciseInterval_q(oEi), .exerciseDuration_q(oEd),
		.heatingStartDelay_q(oHs), .boilerStartDelay_q(oBs),
		.systemStartDelay_q(oSs), .aux1StartDelay_q(oAs),
		.heatingDemandOpts_q(oHd), .heatingForceOpts_q(oHf),
		.hotWaterDemandOpts_q(oWd), .heatingDemandFlags_q(oHdf),
		.hotWaterDemandFlags_q(oWdf), .heatingForceFlags_q(oHff));
	function automatic integer ix(input logic [15:0] a);
		ix = (a >= 16'h011B && a <= 16'h012A) ? a - 16'h011B : 99;
	endfunction
	function automatic logic [15:0] nx(input integer n, input logic [15:0] o, d);
		case (n)
		1, 4: nx = d <= 16'h0003 ? d : o;
		2, 5: nx = d <= 16'h0001 ? d : o;
		3: nx = 16'h0000;
		7: nx = d;
		13, 15: nx = d & 16'hE06F;
		14: nx = d & 16'hC1FF;
		default: nx = (d <= 16'hFD20 || d == 16'hFFFF) ? d : o;
		endcase
	endfunction
	task automatic chk(input logic [15:0] got, exp);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Level outputs settle two edges after the write, long before a read ends
	task automatic levels;
		chk(oBo, sh[0]);
		chk({14'h0000, oAx}, sh[1]);
		chk({15'h0000, oAc}, sh[2]);
		chk({14'h0000, oSx}, sh[4]);
		chk({15'h0000, oSc}, sh[5]);
		chk(oSo, sh[6]);
		chk(oEi, sh[7]);
		chk(oEd, sh[8]);
		chk(oHs, sh[9]);
		chk(oBs, sh[10]);
		chk(oSs, sh[11]);
		chk(oAs, sh[12]);
		chk(oHd, sh[13]);
		chk(oHf, sh[14]);
		chk(oWd, sh[15]);
		chk({7'h00, oHdf}, {7'h00, sh[13][15:13], sh[13][6:5],
			sh[13][3:0]});
		chk({7'h00, oWdf}, {7'h00, sh[15][15:13], sh[15][6:5],
			sh[15][3:0]});
		chk({5'h00, oHff}, {5'h00, sh[14][15:14],
			sh[14][8:0]});
	endtask
	task automatic rd(input logic [15:0] a);
		expq.push_back(ix(a) < 16 ? sh[ix(a)] : 16'h0000);
		pump_bus_master_inst.access(1'b0, a, 16'h0000);
	endtask
	task automatic wr(input logic [15:0] a, d);
		if (ix(a) < 16) sh[ix(a)] = nx(ix(a), sh[ix(a)], d);
		pump_bus_master_inst.access(1'b1, a, d);
	endtask
	task end_of_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(negedge clk) begin
		cycles = cycles + 1;
		if (rdValid_q === 1'b1) begin
			v = expq.size() > 0 ? expq.pop_front() : ~rdData_q;
			n_tests = n_tests + 1;
			if (rdData_q !== v) begin
				fail_count = fail_count + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, rdData_q, v);
			end
		end
		if (cycles > 8000) begin
			fail_count = fail_count + 1;
			end_of_test();
		end
	end
	initial begin
		// Two passes so the second reset lands on a dirty bank
		for (i = 0; i < 2; i = i + 1) begin
			rst = 1'b1;
			for (k = 0; k < 16; k = k + 1)
				sh[k] = (k == 0 || k == 6 || (k >= 8 && k <= 12)) ?
					16'hFFFF : 16'h0000;
			repeat (16) @(posedge clk);
			#1;
			rst = 1'b0;
			for (k = 0; k < 18; k = k + 1)
				rd(16'h011A + k[15:0]);
			levels();
			for (k = 0; k < 18; k = k + 1)
				for (j = 0; j < 9; j = j + 1) begin
					wr(16'h011A + k[15:0], bnd[j]);
					rd(16'h011A + k[15:0]);
					levels();
				end
			for (k = 0; k < 100; k = k + 1) begin
				j = $unsigned($random(seed)) % 18;
				r = $random(seed);
				wr(16'h011A + j[15:0], r[15] ? r & 16'h0007 : r);
				rd(16'h011A + j[15:0]);
				levels();
			end
		end
		repeat (4) @(posedge clk);
		if (expq.size() != 0)
			fail_count = fail_count + 1;
		end_of_test();
	end
endmodule // pump_config_register_bank_tb
`default_nettype wire
